// ### rtl/tocu_top.sv
`timescale 1ns/1ps
module tocu_top
    import tocu_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic [5:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    output logic      [31:0]   avs_readdata_o,
    output logic               avs_waitrequest_o,
    input  wire logic [W-1:0]  timer_count_value_i,
    input  wire logic [W-1:0]  capture_value_reg_i,
    input  wire logic          timer_tick_i,
    input  wire logic          counter_write_i,
    input  wire logic          count_down_i,
    input  wire logic          top_reached_i,
    input  wire logic          zero_reached_strobe_i,
    input  wire logic [1:0]    irq_ack_i,
    input  wire logic [1:0]    port_data_i,
    input  wire logic [1:0]    port_dir_i,
    output logic      [1:0]    irq_o,
    output logic      [W-1:0]  limit_value_o,
    output logic               match_block_o,
    output logic      [1:0]    pin_o,
    output logic      [1:0]    pin_oe_n_o,
    output logic      [1:0]    channel_output_state_o
);

    // ------------------------------------------------------------
    // bus slave: one wait cycle on every access
    // ------------------------------------------------------------
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        req;
    logic        wr_en;
    logic [31:0] rd_mux;

    assign req               = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack_q;
    assign wr_en             = avs_write_i && ack_q;
    assign avs_readdata_o    = rdata_q;

    // read data is captured in the wait cycle so it stands at the ack edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= req && !ack_q;
            rdata_q <= (avs_read_i && !ack_q) ? rd_mux : rdata_q;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire sel_ctrl   = (avs_address_i == OFS_CTRL);
    wire sel_force  = (avs_address_i == OFS_FORCE);
    wire sel_irqen  = (avs_address_i == OFS_IRQEN);
    wire sel_flags  = (avs_address_i == OFS_FLAGS);
    wire sel_cmpalo = (avs_address_i == OFS_CMPALO);
    wire sel_cmpahi = (avs_address_i == OFS_CMPAHI);
    wire sel_cmpblo = (avs_address_i == OFS_CMPBLO);
    wire sel_cmpbhi = (avs_address_i == OFS_CMPBHI);
    wire sel_state  = (avs_address_i == OFS_STATE);
    wire [7:0] wbyte = avs_writedata_i[7:0];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    tocu_ctrl_t ctrl_q;
    logic [1:0] irqen_q;
    logic [7:0] stage_q;
    logic       block_q;

    // staging byte is shared by both channels; high byte must go first
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q  <= tocu_ctrl_t'(CTRL_RESET);
            irqen_q <= 2'h0;
            stage_q <= 8'h00;
        end else begin
            if (wr_en && sel_ctrl) ctrl_q <= tocu_ctrl_t'(wbyte);
            if (wr_en && sel_irqen) irqen_q <= wbyte[1:0];
            if (wr_en && (sel_cmpahi || sel_cmpbhi)) stage_q <= wbyte;
        end
    end

    // a counter write blocks matches until the next timer tick is consumed
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            block_q <= 1'b0;
        end else begin
            block_q <= counter_write_i || (block_q && !timer_tick_i);
        end
    end
    // the counter uses this to skip a limit match after a write
    assign match_block_o = block_q;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire [3:0] mode = ctrl_q.mode;
    wire is_nonpwm  = (mode == WM_NORMAL) || (mode == WM_CTC_A) ||
                      (mode == WM_CTC_CAP) || (mode == WM_RSVD);
    wire is_pwm     = !is_nonpwm;
    wire is_fast    = (mode == WM_FAST8) || (mode == WM_FAST9) ||
                      (mode == WM_FAST10) || (mode == WM_FAST_CAP) ||
                      (mode == WM_FAST_A);
    wire upd_zero   = (mode == WM_PFC_CAP) || (mode == WM_PFC_A);
    wire toggle_a   = (mode == WM_FAST_A) || (mode == WM_PFC_A) || (mode == WM_PC_A);
    wire [1:0] act [2];
    assign act[0] = ctrl_q.act_a;
    assign act[1] = ctrl_q.act_b;

    // fixed limits mask the compare value on write
    logic [W-1:0] cmp_mask;
    assign cmp_mask = ((mode == WM_PC8)  || (mode == WM_FAST8))  ? LIMIT_8BIT[W-1:0]  :
                      ((mode == WM_PC9)  || (mode == WM_FAST9))  ? LIMIT_9BIT[W-1:0]  :
                      ((mode == WM_PC10) || (mode == WM_FAST10)) ? LIMIT_10BIT[W-1:0] :
                      LIMIT_MAX[W-1:0];

    // transfer point: zero for frequency-correct modes, limit otherwise
    wire load = timer_tick_i && (upd_zero ? zero_reached_strobe_i : top_reached_i);
    wire zero_tick = timer_tick_i && zero_reached_strobe_i;
    wire [W-1:0] wr_value = {stage_q, wbyte} & cmp_mask;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    logic [W-1:0] active [2];
    logic [W-1:0] buffer [2];
    logic [1:0]   match_w;
    logic [1:0]   flag_w;
    logic [1:0]   force_fire;
    logic [1:0]   state_q;
    logic [1:0]   state_d;
    logic [1:0]   pin_q;
    wire  [1:0]   wr_lo    = {wr_en && sel_cmpblo, wr_en && sel_cmpalo};
    wire  [1:0]   flag_clr = irq_ack_i | ({2{wr_en && sel_flags}} & wbyte[1:0]);

    // force strobes act only outside pulse-width modes
    assign force_fire = {2{wr_en && sel_force && is_nonpwm}} & wbyte[1:0];

    for (genvar i = 0; i < 2; i++) begin : g_ch
        tocu_channel #(
            .W (W)
        ) u_ch (
            .clk_i      (clk_i),
            .reset_i    (reset_i),
            .wr_i       (wr_lo[i]),
            .wr_value_i (wr_value),
            .buffered_i (is_pwm),
            .load_i     (load),
            .tick_i     (timer_tick_i),
            .count_i    (timer_count_value_i),
            .block_i    (block_q),
            .flag_clr_i (flag_clr[i]),
            .active_o   (active[i]),
            .buffer_o   (buffer[i]),
            .match_o    (match_w[i]),
            .flag_o     (flag_w[i])
        );

        // waveform generator: next output state
        always_comb begin
            state_d[i] = state_q[i];
            if (is_nonpwm) begin
                if (match_w[i] || force_fire[i]) begin
                    unique case (act[i])
                        ACT_NONE:   state_d[i] = state_q[i];
                        ACT_TOGGLE: state_d[i] = !state_q[i];
                        ACT_CLEAR:  state_d[i] = 1'b0;
                        ACT_SET:    state_d[i] = 1'b1;
                    endcase
                end
            end else if (match_w[i]) begin
                if (act[i] == ACT_CLEAR) begin
                    state_d[i] = is_fast ? 1'b0 : count_down_i;
                end else if (act[i] == ACT_SET) begin
                    state_d[i] = is_fast ? 1'b1 : !count_down_i;
                end else if (act[i] == ACT_TOGGLE && i == 0 && toggle_a) begin
                    state_d[i] = !state_q[i];
                end
            end else if (is_fast && zero_tick) begin
                if (act[i] == ACT_CLEAR) begin
                    state_d[i] = 1'b1;
                end else if (act[i] == ACT_SET) begin
                    state_d[i] = 1'b0;
                end
            end
        end

        // a nonzero action replaces the port data with the output state
        assign pin_oe_n_o[i] = !port_dir_i[i];
    end

    // output state only moves on its own events, never on a mode change
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= 2'b00;
            pin_q   <= 2'b00;
        end else begin
            state_q <= state_d;
            pin_q[0] <= (act[0] != ACT_NONE) ? state_q[0] : port_data_i[0];
            pin_q[1] <= (act[1] != ACT_NONE) ? state_q[1] : port_data_i[1];
        end
    end

    assign pin_o                  = pin_q;
    assign channel_output_state_o = state_q;
    assign irq_o                  = flag_w & irqen_q;

    // ------------------------------------------------------------
    // counter limit
    // ------------------------------------------------------------
    // capture input is only read here, the action bits never reach it
    assign limit_value_o =
        ((mode == WM_CTC_A) || (mode == WM_PFC_A) ||
         (mode == WM_PC_A) || (mode == WM_FAST_A))     ? active[0] :
        ((mode == WM_CTC_CAP) || (mode == WM_PFC_CAP) ||
         (mode == WM_PC_CAP) || (mode == WM_FAST_CAP)) ? capture_value_reg_i :
        (cmp_mask != LIMIT_MAX[W-1:0])                 ? cmp_mask :
        LIMIT_MAX[W-1:0];

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // compare bytes come straight from the visible register
    wire [W-1:0] vis_a = is_pwm ? buffer[0] : active[0];
    wire [W-1:0] vis_b = is_pwm ? buffer[1] : active[1];
    assign rd_mux = sel_ctrl   ? {24'h000000, ctrl_q}          :
                    sel_irqen  ? {30'h0, irqen_q}              :
                    sel_flags  ? {30'h0, flag_w}               :
                    sel_cmpalo ? {24'h000000, vis_a[7:0]}      :
                    sel_cmpahi ? {24'h000000, vis_a[15:8]}     :
                    sel_cmpblo ? {24'h000000, vis_b[7:0]}      :
                    sel_cmpbhi ? {24'h000000, vis_b[15:8]}     :
                    sel_state  ? {30'h0, state_q}              :
                    32'h00000000;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_flag_on_match: assert property (match_w[0] |=> flag_w[0])
        else $error("match did not set flag a");
    // clearing: a serviced interrupt or a written one, unless a match lands
    a_ack_clears: assert property ((irq_ack_i[0] && !match_w[0]) |=> !flag_w[0])
        else $error("serviced irq left flag a set");
    a_w1c_flag: assert property ((wr_en && sel_flags && wbyte[0] && !match_w[0]) |=>
        !flag_w[0])
        else $error("write one did not clear flag a");
    // forcing moves the state only, never the flag
    a_force_no_flag: assert property ((force_fire[0] && !match_w[0] && !flag_w[0]) |=>
        !flag_w[0])
        else $error("force set flag a");

    // compare value path: blocking, direct writes, buffering, masking
    a_block_match: assert property (counter_write_i |=> (match_w == 2'b00))
        else $error("match seen right after counter write");
    a_direct_write: assert property ((wr_lo[0] && is_nonpwm) |=>
        active[0] == $past(wr_value))
        else $error("unbuffered write missed active register");
    // a write one cycle earlier may still have been a direct one
    a_buffer_hold: assert property ((is_pwm && !load && !$past(wr_lo[1])) |=>
        $stable(active[1]))
        else $error("buffered compare changed off the load point");
    a_mask_fixed: assert property ((wr_lo[0] && mode == WM_FAST8) |=>
        buffer[0][15:8] == 8'h00)
        else $error("unused compare bits not masked");

    // output state: actions, forces and the pulse-width lockout
    a_force_toggle: assert property ((force_fire[0] && !match_w[0] && act[0] == ACT_TOGGLE)
        |=> state_q[0] != $past(state_q[0]) ##1 flag_w[0] == $past(flag_w[0], 2) || irq_ack_i[0]
        || $past(flag_clr[0]))
        else $error("force did not toggle state");
    a_set_action: assert property (((match_w[0] || force_fire[0]) && is_nonpwm &&
        act[0] == ACT_SET) |=> state_q[0])
        else $error("set action left state a low");
    a_clear_action: assert property (((match_w[0] || force_fire[0]) && is_nonpwm &&
        act[0] == ACT_CLEAR) |=> !state_q[0])
        else $error("clear action left state a high");
    a_none_holds: assert property (((match_w[0] || force_fire[0]) && is_nonpwm &&
        act[0] == ACT_NONE) |=> $stable(state_q[0]))
        else $error("action zero changed state a");
    // a tick may move the state legally, so only idle-timer forces are judged
    a_pwm_force_off: assert property ((wr_en && sel_force && is_pwm && !timer_tick_i) |=>
        $stable(state_q[0]))
        else $error("force acted in a pulse-width mode");

    // pin source follows the action bits with one register of delay
    a_pin_override: assert property ((act[0] != ACT_NONE) [*2] |->
        pin_q[0] == $past(state_q[0]))
        else $error("pin not driven from output state");
    a_pin_port: assert property ((act[0] == ACT_NONE) [*2] |->
        pin_q[0] == $past(port_data_i[0]))
        else $error("pin not driven from port data");
    // counter limit and bus timing
    a_limit_a: assert property ((mode == WM_FAST_A) |-> limit_value_o == active[0])
        else $error("limit not taken from channel a");
    a_bus_wait: assert property ((req && !ack_q) |=> !avs_waitrequest_o)
        else $error("bus answer later than one wait cycle");

    // main scenarios worth seeing at least once
    c_match_irq: cover property (match_w[0] && irqen_q[0] ##1 irq_o[0]);
    c_pwm_load:  cover property (is_pwm && load && (active[0] != buffer[0]));
    c_force:     cover property (force_fire[0] && act[0] == ACT_SET);
    c_block_hit: cover property (block_q && timer_tick_i && timer_count_value_i == active[0]);
    c_flag_clear: cover property (flag_w[0] ##1 !flag_w[0]);

endmodule : tocu_top

// ### rtl/tocu_pkg.sv
package tocu_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_FORCE  = 6'h04;
    localparam logic [5:0] OFS_IRQEN  = 6'h08;
    localparam logic [5:0] OFS_FLAGS  = 6'h0c;
    localparam logic [5:0] OFS_CMPALO = 6'h10;
    localparam logic [5:0] OFS_CMPAHI = 6'h14;
    localparam logic [5:0] OFS_CMPBLO = 6'h18;
    localparam logic [5:0] OFS_CMPBHI = 6'h1c;
    localparam logic [5:0] OFS_STATE  = 6'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_ACTA_LSB = 4;
    localparam int          CTRL_ACTB_LSB = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] CMP_RESET     = 16'h0000;
    localparam logic [15:0] LIMIT_MAX     = 16'hffff;
    localparam logic [15:0] LIMIT_8BIT    = 16'h00ff;
    localparam logic [15:0] LIMIT_9BIT    = 16'h01ff;
    localparam logic [15:0] LIMIT_10BIT   = 16'h03ff;

    // ------------------------------------------------------------
    // waveform modes and output actions
    // ------------------------------------------------------------
    localparam logic [3:0] WM_NORMAL   = 4'h0;
    localparam logic [3:0] WM_PC8      = 4'h1;
    localparam logic [3:0] WM_PC9      = 4'h2;
    localparam logic [3:0] WM_PC10     = 4'h3;
    localparam logic [3:0] WM_CTC_A    = 4'h4;
    localparam logic [3:0] WM_FAST8    = 4'h5;
    localparam logic [3:0] WM_FAST9    = 4'h6;
    localparam logic [3:0] WM_FAST10   = 4'h7;
    localparam logic [3:0] WM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WM_PFC_A    = 4'h9;
    localparam logic [3:0] WM_PC_CAP   = 4'ha;
    localparam logic [3:0] WM_PC_A     = 4'hb;
    localparam logic [3:0] WM_CTC_CAP  = 4'hc;
    localparam logic [3:0] WM_RSVD     = 4'hd;
    localparam logic [3:0] WM_FAST_CAP = 4'he;
    localparam logic [3:0] WM_FAST_A   = 4'hf;

    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    typedef struct packed {
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] mode;
    } tocu_ctrl_t;

    typedef struct packed {
        logic        tick;
        logic        top;
        logic        zero;
        logic        down;
        logic [15:0] count;
    } tocu_timer_t;

endpackage : tocu_pkg

// ### rtl/tocu_channel.sv
`timescale 1ns/1ps
module tocu_channel
    import tocu_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          wr_i,
    input  wire logic [W-1:0]  wr_value_i,
    input  wire logic          buffered_i,
    input  wire logic          load_i,
    input  wire logic          tick_i,
    input  wire logic [W-1:0]  count_i,
    input  wire logic          block_i,
    input  wire logic          flag_clr_i,
    output logic      [W-1:0]  active_o,
    output logic      [W-1:0]  buffer_o,
    output logic               match_o,
    output logic               flag_o
);

    logic [W-1:0] buf_q;
    logic [W-1:0] buf_d;
    logic [W-1:0] act_q;
    logic [W-1:0] act_d;
    logic         flag_q;
    logic         flag_d;

    // ------------------------------------------------------------
    // compare value staging
    // ------------------------------------------------------------
    // unbuffered writes land directly in the active register
    assign buf_d = wr_i ? wr_value_i : buf_q;
    assign act_d = (wr_i && !buffered_i)   ? wr_value_i :
                   (load_i && buffered_i)  ? buf_q      :
                   act_q;

    // ------------------------------------------------------------
    // match and flag
    // ------------------------------------------------------------
    // full width compare, sampled on each timer tick
    assign match_o = tick_i && (count_i == act_q) && !block_i;
    // a match in the clear cycle wins over the clear
    assign flag_d  = match_o || (flag_q && !flag_clr_i);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            buf_q  <= CMP_RESET[W-1:0];
            act_q  <= CMP_RESET[W-1:0];
            flag_q <= 1'b0;
        end else begin
            buf_q  <= buf_d;
            act_q  <= act_d;
            flag_q <= flag_d;
        end
    end

    assign active_o = act_q;
    assign buffer_o = buf_q;
    assign flag_o   = flag_q;

endmodule : tocu_channel

// ### tb/tocu_cnt_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// counter model on the timer side
// ----------------------------------------
module tocu_cnt_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    input  wire logic [15:0] limit_i,
    output logic      [15:0] count_o,
    output logic             tick_o,
    output logic             top_o,
    output logic             zero_o,
    output logic             wr_o
);
    // up-count only, so no zero write happens while counting down
    assign tick_o = run_i;
    assign top_o  = run_i && (count_o == limit_i);
    assign zero_o = run_i && (count_o == 16'h0000);
    assign wr_o   = load_i;
    // a processor write wins over counting
    always @(posedge clk_i) begin
        if (load_i) count_o <= load_val_i;
        else if (run_i) count_o <= top_o ? 16'h0000 : count_o + 16'h0001;
    end
endmodule : tocu_cnt_model

// ### tb/timer16_output_compare_unit_test.sv
`timescale 1ns/1ps
module timer16_output_compare_unit_test;
    import tocu_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk = 0, rst = 1, rd = 0, wr = 0, run = 0, ld = 0;
    logic [5:0]  adr = 0;
    logic [31:0] wd = 0, rdata, rv;
    logic        wt, tick, top, zero, cwr, mblk;
    logic [15:0] cnt, lim, ldv = 0;
    logic [1:0]  ack = 0, pd = 2'b10, pdir = 2'b11, irq, pin, oen, st;
    logic [31:0] exp_q[$];
    int          n_fail = 0, checks_done = 0;
    integer      seed = 32'hb95b9656;
    always #2 clk = ~clk;
    tocu_cnt_model cm (.clk_i(clk), .run_i(run), .load_i(ld), .load_val_i(ldv),
        .limit_i(lim), .count_o(cnt), .tick_o(tick), .top_o(top), .zero_o(zero), .wr_o(cwr));
    tocu_top dut (.clk_i(clk), .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wt), .timer_count_value_i(cnt), .capture_value_reg_i(16'h0100),
        .timer_tick_i(tick), .counter_write_i(cwr), .count_down_i(1'b0),
        .top_reached_i(top), .zero_reached_strobe_i(zero), .irq_ack_i(ack),
        .port_data_i(pd), .port_dir_i(pdir), .irq_o(irq), .limit_value_o(lim),
        .match_block_o(mblk), .pin_o(pin), .pin_oe_n_o(oen), .channel_output_state_o(st));
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checks_done++;
        if (seen !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // one access; only the watchdog ends a wait that never sees waitrequest low
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge clk);
        if (!w) exp_q.push_back({24'h0, e});
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= {24'h0, d};
        do @(posedge clk); while (wt !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc
    task automatic cmp_wr(input logic [5:0] lo, input logic [15:0] v);
        acc(1, lo + 6'h04, v[15:8], 0);
        acc(1, lo, v[7:0], 0);
    endtask : cmp_wr
    task automatic pulse_ld(input logic [15:0] v);
        @(posedge clk);
        ldv <= v;
        ld  <= 1'b1;
        @(posedge clk);
        ld  <= 1'b0;
    endtask : pulse_ld
    task automatic run_to_irq;
        int n;
        n = 0;
        @(posedge clk);
        run <= 1'b1;
        while (irq[0] !== 1'b1 && n < 100) begin @(posedge clk); n++; end
        run <= 1'b0;
        check("irq", irq, 2'b01);
    endtask : run_to_irq
    // read data taken at the edge where the read is accepted
    always @(posedge clk) begin
        if (rd && wt === 1'b0) check("readdata", rdata, exp_q.pop_front());
    end
    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        acc(0, OFS_CTRL, 0, 8'h00);
        acc(0, OFS_STATE, 0, 8'h00);
        acc(1, 6'h24, 8'h5a, 0);
        acc(0, 6'h24, 0, 8'h00);
        $display("test reset done");
        // random compare values written direct in normal mode
        for (int i = 0; i < 4; i++) begin
            rv = $random(seed);
            cmp_wr(OFS_CMPBLO, rv[15:0]);
            acc(0, OFS_CMPBLO, 0, rv[7:0]);
            acc(0, OFS_CMPBHI, 0, rv[15:8]);
        end
        cmp_wr(OFS_CMPBLO, 16'hff00);
        $display("test compare access done");
        cmp_wr(OFS_CMPALO, 16'h0020);
        acc(1, OFS_IRQEN, 8'h01, 0);
        pulse_ld(16'h0000);
        run_to_irq();
        acc(0, OFS_FLAGS, 0, 8'h01);
        @(posedge clk);
        ack <= 2'b01;
        @(posedge clk);
        ack <= 2'b00;
        acc(0, OFS_FLAGS, 0, 8'h00);
        pulse_ld(16'h001e);
        run_to_irq();
        acc(1, OFS_FLAGS, 8'h01, 0);
        acc(0, OFS_FLAGS, 0, 8'h00);
        $display("test match flag done");
        // counter written equal to compare: next tick must not match
        pulse_ld(16'h0020);
        repeat (2) @(posedge clk);
        check("match_block", mblk, 1'b1);
        run <= 1'b1;
        repeat (2) @(posedge clk);
        run <= 1'b0;
        acc(0, OFS_FLAGS, 0, 8'h00);
        check("match_block", mblk, 1'b0);
        $display("test match block done");
        for (int i = 0; i < 3; i++) begin
            acc(1, OFS_CTRL, {2'b00, (i == 0) ? ACT_SET : (i == 1) ? ACT_CLEAR : ACT_TOGGLE,
                WM_NORMAL}, 0);
            acc(1, OFS_FORCE, 8'h01, 0);
            acc(0, OFS_STATE, 0, {7'h0, i != 1});
            acc(0, OFS_FLAGS, 0, 8'h00);
            acc(0, OFS_FORCE, 0, 8'h00);
        end
        @(negedge clk);
        check("pin", pin, 2'b11);
        check("oe_n", oen, 2'b00);
        check("state", st, 2'b01);
        acc(1, OFS_CTRL, {4'h0, WM_NORMAL}, 0);
        acc(1, OFS_FORCE, 8'h01, 0);
        acc(0, OFS_STATE, 0, 8'h01);
        @(negedge clk);
        check("pin", pin, 2'b10);
        $display("test force and pin done");
        acc(1, OFS_CTRL, {2'b00, ACT_TOGGLE, WM_FAST8}, 0);
        acc(0, OFS_STATE, 0, 8'h01);
        acc(1, OFS_FORCE, 8'h01, 0);
        acc(0, OFS_STATE, 0, 8'h01);
        check("limit", lim, LIMIT_8BIT);
        cmp_wr(OFS_CMPALO, 16'hffff);
        acc(0, OFS_CMPALO, 0, 8'hff);
        acc(0, OFS_CMPAHI, 0, 8'h00);
        // channel a limit: buffered 0x00ff only reaches the limit at top
        acc(1, OFS_CTRL, {2'b00, ACT_TOGGLE, WM_FAST_A}, 0);
        @(negedge clk);
        check("limit", lim, 16'h0020);
        pulse_ld(16'h001f);
        @(posedge clk);
        run <= 1'b1;
        repeat (2) @(posedge clk);
        run <= 1'b0;
        @(negedge clk);
        check("limit", lim, 16'h00ff);
        acc(0, OFS_STATE, 0, 8'h00);
        acc(0, OFS_FLAGS, 0, 8'h01);
        acc(1, OFS_CTRL, {4'h0, WM_FAST_CAP}, 0);
        @(negedge clk);
        check("limit", lim, 16'h0100);
        $display("test fast mode done");
        give_verdict();
    end
endmodule : timer16_output_compare_unit_test
